// ===== design/cic_top.v
// capture input configuration, free-running counter and four capture channels on ahb-lite
// Behaviour
// R1: edge field 0 falling, 1 rising, 2 both, 3 capture disabled.
// R2: a qualifying edge copies the counter into that channel's capture register.
// R3: bypass bit 1 skips the noise filter; 0 filters the input first.
// R4: a 3-bit field picks the filter sample clock from the timer rates.
// R5: channel 3 uses bits 31:29, 26, 25:24; bits 28:27 reserved.
// R6: channel 2 uses bits 23:21, 18, 17:16; bits 20:19 reserved.
// R7: channel 1 uses bits 15:13, 10, 9:8; bits 12:11 reserved.
// R8: channel 0 uses bits 7:5, 2, 1:0; bits 4:3 reserved.
// R9: reset clears every configuration field to zero.
// R10: capture register 0 is read-only and holds the captured counter value.
// R11: counter is 32 bits, starts at zero, wraps to zero after maximum.
// R12: reserved configuration bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "cic_map.vh"
module cic_top (
	// ahb clock, reset and freeze
	input wire hclk,
	input wire hresetn,
	input wire clk_en,
	// ahb-lite slave
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata_ff,
	output reg hreadyout_ff,
	output reg hresp_ff,
	// capture pins
	input wire timestamp_input_pin_ch0,
	input wire timestamp_input_pin_ch1,
	input wire timestamp_input_pin_ch2,
	input wire timestamp_input_pin_ch3,
	// interrupt
	output reg irq_ff
);
	reg [31:0] cfg_ff;
	reg [31:0] cnt_ff;
	reg [31:0] cap_ff [0:3];
	reg [4:0] irq_stat_ff;
	reg [4:0] irq_en_ff;
	reg [`CIC_PRESC_W-1:0] presc_ff;
	reg wr_pend_ff;
	reg rd_pend_ff;
	reg [11:0] addr_ff;
	reg [31:0] nxt_rdata;
	reg [7:0] tick_vec;
	reg [4:0] nxt_stat;
	wire [3:0] hit;
	wire [3:0] pins;
	wire take;
	wire wrap;
	integer i;

	// field extraction helper; no channel calls it, each slices cfg_ff directly
	function [7:0] ch_field;
		input [31:0] cfg;
		input [1:0] ch;
		begin
			ch_field = cfg[ch*`CIC_CH_STRIDE +: 8];
		end
	endfunction

	assign pins = {timestamp_input_pin_ch3, timestamp_input_pin_ch2,
		timestamp_input_pin_ch1, timestamp_input_pin_ch0};
	assign take = hsel & hready & htrans[1];
	assign wrap = (cnt_ff == 32'hffffffff);

	// sample-rate ticks: rate k fires every 2**k cycles, rate 0 every cycle
	always @* begin
		tick_vec[0] = 1'b1;
		// a variable mask keeps the part-select constant for strict front ends
		for (i = 1; i < 8; i = i + 1)
			tick_vec[i] = ((presc_ff & ((8'h01 << i) - 8'h01)) == ((8'h01 << i) - 8'h01));
	end

	// four channels, one filter instance each; each reads its own slice
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gch
			cic_filter u_filt (
				.hclk(hclk),
				.hresetn(hresetn),
				.clk_en(clk_en),
				.tick_vec(tick_vec),
				.fclk_sel(cfg_ff[g*`CIC_CH_STRIDE+`CIC_FCLK_LSB +: 3]), // R5 R6 R7 R8
				.skip(cfg_ff[g*`CIC_CH_STRIDE+`CIC_SKIP_BIT]), // R5 R6 R7 R8
				.edge_sel(cfg_ff[g*`CIC_CH_STRIDE+`CIC_EDGE_LSB +: 2]), // R5 R6 R7 R8
				.pin(pins[g]),
				.hit_ff(hit[g])
			);
		end
	endgenerate

	// read mux in the data phase; unmapped words read zero
	always @* begin
		case (addr_ff)
			`CIC_OFF_CFG: nxt_rdata = cfg_ff & `CIC_CFG_MASK; // R12
			`CIC_OFF_COUNTER: nxt_rdata = cnt_ff;
			`CIC_OFF_CAP0: nxt_rdata = cap_ff[0]; // R10
			`CIC_OFF_CAP1: nxt_rdata = cap_ff[1];
			`CIC_OFF_CAP2: nxt_rdata = cap_ff[2];
			`CIC_OFF_CAP3: nxt_rdata = cap_ff[3];
			`CIC_OFF_IRQ_STATUS: nxt_rdata = {27'h0, irq_stat_ff};
			`CIC_OFF_IRQ_ENABLE: nxt_rdata = {27'h0, irq_en_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// sticky status: hardware set wins over a same-cycle software clear
	always @* begin
		nxt_stat = irq_stat_ff;
		if (wr_pend_ff && addr_ff == `CIC_OFF_IRQ_CLEAR)
			nxt_stat = nxt_stat & ~hwdata[4:0];
		nxt_stat = nxt_stat | {wrap, hit};
	end

	// bus, configuration, counter and capture registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= `CIC_CFG_RESET; // R9
			cnt_ff <= `CIC_CNT_RESET; // R11
			for (i = 0; i < 4; i = i + 1)
				cap_ff[i] <= 32'h00000000;
			irq_stat_ff <= 5'h00;
			irq_en_ff <= 5'h00;
			presc_ff <= {`CIC_PRESC_W{1'b0}};
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff <= 12'h000;
			hrdata_ff <= 32'h00000000;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			presc_ff <= presc_ff + 1'b1;
			cnt_ff <= cnt_ff + 32'h00000001; // R11
			// latch the address phase; writes have no wait state
			wr_pend_ff <= take & hwrite;
			rd_pend_ff <= take & ~hwrite;
			// reads take one wait state so the mux already sees a write that just landed
			hreadyout_ff <= ~(take & ~hwrite);
			if (take)
				addr_ff <= {haddr[11:2], 2'b00};
			if (rd_pend_ff)
				hrdata_ff <= nxt_rdata;
			// captures: each channel latches the counter on its own edge
			for (i = 0; i < 4; i = i + 1)
				if (hit[i])
					cap_ff[i] <= cnt_ff; // R2
			if (wr_pend_ff) begin
				case (addr_ff)
					`CIC_OFF_CFG: cfg_ff <= hwdata & `CIC_CFG_MASK; // R12
					`CIC_OFF_COUNTER: cnt_ff <= hwdata;
					`CIC_OFF_IRQ_ENABLE: irq_en_ff <= hwdata[4:0];
					default: ;
				endcase
			end
			irq_stat_ff <= nxt_stat;
			irq_ff <= |(nxt_stat & irq_en_ff);
		end
	end
endmodule // cic_top
`default_nettype wire

// ===== design/cic_map.vh
// register offsets, field positions, reset values and timing counts of the capture input block
`ifndef CIC_MAP_VH
`define CIC_MAP_VH
`define CIC_OFF_CFG 12'h004
`define CIC_OFF_COUNTER 12'h00c
`define CIC_OFF_CAP0 12'h010
`define CIC_OFF_CAP1 12'h014
`define CIC_OFF_CAP2 12'h018
`define CIC_OFF_CAP3 12'h01c
`define CIC_OFF_IRQ_STATUS 12'h020
`define CIC_OFF_IRQ_ENABLE 12'h024
`define CIC_OFF_IRQ_CLEAR 12'h028
`define CIC_CH_STRIDE 8
`define CIC_EDGE_LSB 0
`define CIC_SKIP_BIT 2
`define CIC_FCLK_LSB 5
`define CIC_CFG_MASK 32'he7e7e7e7
`define CIC_CFG_RESET 32'h00000000
`define CIC_CNT_RESET 32'h00000000
`define CIC_EDGE_FALL 2'h0
`define CIC_EDGE_RISE 2'h1
`define CIC_EDGE_BOTH 2'h2
`define CIC_EDGE_OFF 2'h3
`define CIC_FILT_LEN 3'h3
`define CIC_PRESC_W 8
`endif

// ===== design/cic_filter.v
// one capture channel: input filter with selectable sample rate and edge detector
`timescale 1ns/1ps
`default_nettype none
`include "cic_map.vh"
module cic_filter (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	input wire clk_en,
	// prescaler ticks, one per selectable sample rate
	input wire [7:0] tick_vec,
	// channel configuration
	input wire [2:0] fclk_sel,
	input wire skip,
	input wire [1:0] edge_sel,
	// pin and result
	input wire pin,
	output reg hit_ff
);
	reg raw_ff;
	reg [2:0] hist_ff;
	reg filt_ff;
	reg prev_ff;
	wire cur;
	wire rise;
	wire fall;
	reg nxt_hit;

	// bypass feeds the raw sample straight to the edge detector
	assign cur = skip ? raw_ff : filt_ff; // R3
	assign rise = cur & ~prev_ff;
	assign fall = ~cur & prev_ff;

	// edge select decode
	always @* begin
		case (edge_sel)
			`CIC_EDGE_FALL: nxt_hit = fall; // R1
			`CIC_EDGE_RISE: nxt_hit = rise; // R1
			`CIC_EDGE_BOTH: nxt_hit = rise | fall; // R1
			default: nxt_hit = 1'b0; // R1
		endcase
	end

	// filter needs three equal samples at the chosen rate before the level moves
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_ff <= 1'b0;
			hist_ff <= 3'h0;
			filt_ff <= 1'b0;
			prev_ff <= 1'b0;
			hit_ff <= 1'b0;
		end else if (clk_en) begin
			raw_ff <= pin;
			if (tick_vec[fclk_sel]) begin // R4
				hist_ff <= {hist_ff[1:0], raw_ff};
				if (hist_ff == {3{1'b1}})
					filt_ff <= 1'b1;
				else if (hist_ff == 3'h0)
					filt_ff <= 1'b0;
			end
			prev_ff <= cur;
			hit_ff <= nxt_hit;
		end
	end
endmodule // cic_filter
`default_nettype wire

// ===== bench/cic_props.sv
// assertions on the bus and interrupt ports of the capture input block
`timescale 1ns/1ps
`default_nettype none
`include "cic_map.vh"
module cic_props (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata_ff,
	input wire logic hreadyout_ff,
	input wire logic hresp_ff,
	// pin and interrupt
	input wire logic timestamp_input_pin_ch0,
	input wire logic irq_ff
);
	logic take;
	logic wr_cfg_ff, wr_en_ff, rd_cfg_ff, rd_ff;
	logic [31:0] cfg_ff, en_ff;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	assign take = hsel && hreadyout_ff && htrans[1];
	// shadows of config and enable, updated at the end of each data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_cfg_ff, wr_en_ff, rd_cfg_ff, rd_ff} <= 4'h0;
			cfg_ff <= 32'h0;
			en_ff <= 32'h0;
		end else begin
			wr_cfg_ff <= take && hwrite && haddr == `CIC_OFF_CFG;
			wr_en_ff <= take && hwrite && haddr == `CIC_OFF_IRQ_ENABLE;
			rd_cfg_ff <= take && !hwrite && haddr == `CIC_OFF_CFG;
			rd_ff <= take && !hwrite;
			if (wr_cfg_ff)
				cfg_ff <= hwdata & `CIC_CFG_MASK;
			if (wr_en_ff)
				en_ff <= hwdata;
		end
	end
	a_ready_back: assert property (!hreadyout_ff |=> hreadyout_ff) else $error("ready stuck");
	a_resp_okay: assert property (!hresp_ff) else $error("bad resp");
	a_reset_quiet: assert property ($rose(hresetn) |-> hrdata_ff == 32'h0 && !irq_ff)
		else $error("reset state");
	a_cfg_echo: assert property (rd_cfg_ff |=> hrdata_ff == cfg_ff)
		else $error("cfg read");
	a_data_hold: assert property (!rd_ff |=> $stable(hrdata_ff)) else $error("data moved");
	a_irq_masked: assert property ((en_ff[4:0] == 5'h0) [*2] |-> !irq_ff)
		else $error("masked irq");
	a_rise_capt: assert property ($rose(timestamp_input_pin_ch0) && cfg_ff[2:0] == 3'h5
		&& en_ff[0] |-> ##[1:8] irq_ff) else $error("no rise capture");
	a_fall_capt: assert property ($fell(timestamp_input_pin_ch0) && cfg_ff[2:0] == 3'h4
		&& en_ff[0] |-> ##[1:8] irq_ff) else $error("no fall capture");
	c_cfg_read: cover property (rd_cfg_ff);
	c_irq: cover property (irq_ff);
	c_pin_rise: cover property ($rose(timestamp_input_pin_ch0));
endmodule // cic_props
`default_nettype wire

// ===== bench/cic_pins.sv
// capture pin sources standing in for the external signals
`timescale 1ns/1ps
`default_nettype none
module cic_pins (
	// clock
	input wire logic hclk,
	// requested and driven levels
	input wire logic [3:0] want,
	output logic [3:0] pins
);
	// levels move just after an edge, like a synchronous source
	always @(posedge hclk) begin
		pins <= want;
	end
endmodule // cic_pins
`default_nettype wire

// ===== bench/capture_input_config_ch0_3_tb.sv
// bench for the capture input block: bus task, scenarios and verdict
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module capture_input_config_ch0_3_tb;
	logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout_ff, hresp_ff, irq_ff;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata_ff, rd, c1;
	logic [3:0] want, pins;
	int num_errors, n_checks;
	cic_top u_dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout_ff), .hrdata_ff, .hreadyout_ff, .hresp_ff,
		.timestamp_input_pin_ch0(pins[0]), .timestamp_input_pin_ch1(pins[1]),
		.timestamp_input_pin_ch2(pins[2]), .timestamp_input_pin_ch3(pins[3]), .irq_ff);
	cic_pins u_pins (.hclk, .want, .pins);
	// one single transfer; read data is taken at the edge that ends the data phase
	task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout_ff !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout_ff !== 1'b1);
		rd = hrdata_ff;
	endtask
	// reset values, reserved bits and a read-only capture register
	task t_regs;
		bus(12'h004, 1'b0, 32'h0);
		`CK(rd, 32'h0)
		bus(12'h004, 1'b1, 32'hffffffff);
		bus(12'h004, 1'b0, 32'h0);
		`CK(rd, 32'he7e7e7e7)
		bus(12'h010, 1'b1, 32'hffffffff);
		bus(12'h010, 1'b0, 32'h0);
		`CK(rd, 32'h0)
		bus(12'h024, 1'b1, 32'h10);
		bus(12'h00c, 1'b1, 32'hfffffff0);
		repeat (30) @(posedge hclk);
		`CK(irq_ff, 1'b1)
		bus(12'h00c, 1'b0, 32'h0);
		`CK(rd < 32'h40, 1'b1)
		bus(12'h028, 1'b1, 32'h1f);
	endtask
	// filtered input: a one-cycle pulse is dropped, a slow sample rate delays the edge
	task t_filter;
		bus(12'h004, 1'b1, 32'h1);
		bus(12'h024, 1'b1, 32'h1);
		bus(12'h028, 1'b1, 32'h1f);
		want[0] <= 1'b1;
		@(posedge hclk);
		want[0] <= 1'b0;
		repeat (10) @(posedge hclk);
		`CK(irq_ff, 1'b0)
		bus(12'h004, 1'b1, 32'he1);
		want[0] <= 1'b1;
		repeat (10) @(posedge hclk);
		`CK(irq_ff, 1'b0)
		repeat (600) @(posedge hclk);
		`CK(irq_ff, 1'b1)
		want[0] <= 1'b0;
		repeat (600) @(posedge hclk);
	endtask
	// every edge mode on every channel, filter bypassed, seen through irq, and through capture in rising mode
	task t_edges;
		for (int c = 0; c < 4; c++) begin
			for (int m = 0; m < 4; m++) begin
				bus(12'h004, 1'b1, (32'h4 | m) << (8 * c));
				bus(12'h024, 1'b1, 32'h1 << c);
				bus(12'h028, 1'b1, 32'h1f);
				bus(12'h00c, 1'b0, 32'h0);
				c1 = rd;
				want[c] <= 1'b1;
				repeat (10) @(posedge hclk);
				`CK(irq_ff, m == 1 || m == 2)
				bus(12'h010 + 12'(4 * c), 1'b0, 32'h0);
				if (m == 1)
					`CK(rd > c1, 1'b1)
				bus(12'h028, 1'b1, 32'h1f);
				want[c] <= 1'b0;
				repeat (10) @(posedge hclk);
				`CK(irq_ff, m == 0 || m == 2)
			end
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// the whole run needs well under a millisecond
	initial begin
		#1000000;
		num_errors++;
		close_out;
	end
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata, want} = '0;
		clk_en = 1'b1;
		hsize = 3'h2;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_edges;
		t_filter;
		close_out;
	end
endmodule // capture_input_config_ch0_3_tb
bind cic_top cic_props u_props (.*);
`default_nettype wire
